// File: rtl/flash_cmd_core.sv
// Command sequencer: erase, write enable, deep sleep and wake on the system clock
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_cmd_core #(
  parameter int unsigned BLK_ERASE_CYC = `US_TO_CYC(`T_BLK_ERASE_US),
  parameter int unsigned CHIP_ERASE_CYC = `US_TO_CYC(`T_CHIP_ERASE_US),
  parameter logic [7:0] MAKER_ID = 8'h5a,
  parameter logic [7:0] DEVICE_ID = 8'h3c
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  input wire logic [4:0] i_protect_field,
  input wire logic i_protect_complement,
  output logic o_busy_in_progress,
  output logic o_write_enable_latch,
  output logic o_deep_sleep,
  output logic o_standby,
  output logic o_erase_chip,
  output logic [6:0] o_erase_blk
);
  import flash_pkg::*;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned ENTER_CYC = `US_TO_CYC(`T_ENTER_SLEEP_US);
  localparam int unsigned WAKE_CYC = `US_TO_CYC(`T_WAKE_US);
  localparam int unsigned WAKE_ID_CYC = `US_TO_CYC(`T_WAKE_ID_US);

  if (BLK_ERASE_CYC < 1 || CHIP_ERASE_CYC < 1) begin : g_chk
    $error("Erase cycle counts must be at least one");
  end

  // ------------------------------------------------------------
  // Protection decode
  // ------------------------------------------------------------
  // Low three field bits size a span of blocks from the top, bit three moves
  // it to the bottom; bit four only refines sector-level cover, not modelled.
  function automatic logic blk_protected(input logic [4:0] bp, input logic cmp,
                                          input logic [6:0] idx);
    logic [7:0] span;
    logic hit;
    span = (bp[2:0] == 3'h7) ? `BLK_COUNT :
           (bp[2:0] == 3'h0) ? 8'h00 : (8'h01 << (bp[2:0] - 3'h1));
    hit = bp[3] ? ({1'b0, idx} < span) : ({1'b0, idx} >= (`BLK_COUNT - span));
    return hit ^ cmp;
  endfunction : blk_protected

  function automatic logic is_bare(input logic [5:0] len);
    return len == `LEN_OPCODE;
  endfunction : is_bare

  // ------------------------------------------------------------
  // Link domain and crossing
  // ------------------------------------------------------------
  logic [7:0] op;
  logic [23:0] addr;
  logic [5:0] len;
  logic link_tog, tog_s, cs_s;
  logic busy_q, busy_d, blocked_q, blocked_d;

  flash_link #(.MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID)) u_link (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_rst(i_rst),
    .i_io(i_io),
    .i_busy(busy_q),
    .i_blocked(blocked_q),
    .o_io(o_io),
    .o_io_oe(o_io_oe),
    .o_op(op),
    .o_addr(addr),
    .o_len(len),
    .o_tog(link_tog)
  );

  // The frame record is quiet once select is high, so it is read directly
  // when the synchronised select rises; the toggle proves the frame had clocks.
  sync3 #(.W(2), .RST(2'b01)) u_sync (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_async({link_tog, i_cs_n}),
    .o_level({tog_s, cs_s})
  );

  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  fl_state_t st_q, st_d;
  logic [31:0] tmr_q, tmr_d;
  logic wel_q, wel_d;
  logic cs_prev_q, cs_prev_d;
  logic seen_q, seen_d;
  logic chip_q, chip_d;
  logic [6:0] blk_q, blk_d;
  logic sleep_q, sleep_d;
  logic standby_q, standby_d;
  logic cs_rise, frame_go, prot_hit, chip_ok;

  always_comb begin
    cs_rise = cs_s && !cs_prev_q;
    frame_go = cs_rise && (tog_s != seen_q);
    prot_hit = blk_protected(i_protect_field, i_protect_complement,
                             addr[`BLK_IDX_MSB:`BLK_IDX_LSB]);
    chip_ok = (i_protect_field[2:0] == 3'h0 && !i_protect_complement) ||
              (i_protect_field[2:0] == 3'h7 && i_protect_complement);
    st_d = st_q;
    wel_d = wel_q;
    chip_d = chip_q;
    blk_d = blk_q;
    cs_prev_d = cs_s;
    seen_d = cs_rise ? tog_s : seen_q;
    tmr_d = (tmr_q != 32'h0) ? tmr_q - 32'h1 : 32'h0;
    case (st_q)
      ST_IDLE: begin
        if (frame_go) begin
          case (op)
            `OP_WR_ENABLE: begin
              if (is_bare(len)) wel_d = 1'b1;
            end
            `OP_BLK_ERASE: begin
              // Any address in the block picks the whole block
              if (len == `LEN_ADDR_CMD && wel_q && !prot_hit) begin
                st_d = ST_ERASE;
                tmr_d = BLK_ERASE_CYC - 32'h1;
                wel_d = 1'b0;
                chip_d = 1'b0;
                blk_d = addr[`BLK_IDX_MSB:`BLK_IDX_LSB];
              end
            end
            `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
              if (is_bare(len) && wel_q && chip_ok) begin
                st_d = ST_ERASE;
                tmr_d = CHIP_ERASE_CYC - 32'h1;
                wel_d = 1'b0;
                chip_d = 1'b1;
              end
            end
            `OP_DEEP_SLEEP: begin
              if (is_bare(len)) begin
                st_d = ST_ENTER;
                tmr_d = ENTER_CYC - 32'h1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_ERASE: begin
        // Every frame is dropped here, including deep sleep and wake
        if (tmr_q == 32'h0) st_d = ST_IDLE;
      end
      ST_ENTER: begin
        if (tmr_q == 32'h0) st_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (frame_go) begin
          case (op)
            `OP_WAKE_ID: begin
              if (is_bare(len)) begin
                st_d = ST_WAKE;
                tmr_d = WAKE_CYC - 32'h1;
              end else if (len >= `LEN_ADDR_CMD) begin
                st_d = ST_WAKE;
                tmr_d = WAKE_ID_CYC - 32'h1;
              end
            end
            `OP_RST_ENABLE, `OP_RST: begin
              if (is_bare(len)) st_d = ST_IDLE;
            end
            default: begin
            end
          endcase
        end
      end
      ST_WAKE: begin
        // Frames during the release delay are not accepted
        if (tmr_q == 32'h0) st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    busy_d = (st_d == ST_ERASE);
    sleep_d = (st_d == ST_SLEEP);
    blocked_d = (st_d == ST_ENTER) || (st_d == ST_SLEEP) || (st_d == ST_WAKE);
    standby_d = cs_s && (st_d == ST_IDLE);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= ST_IDLE;
      tmr_q <= 32'h0;
      wel_q <= 1'b0;
      cs_prev_q <= 1'b1;
      seen_q <= 1'b0;
      chip_q <= 1'b0;
      blk_q <= 7'h00;
      busy_q <= 1'b0;
      sleep_q <= 1'b0;
      blocked_q <= 1'b0;
      standby_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      wel_q <= wel_d;
      cs_prev_q <= cs_prev_d;
      seen_q <= seen_d;
      chip_q <= chip_d;
      blk_q <= blk_d;
      busy_q <= busy_d;
      sleep_q <= sleep_d;
      blocked_q <= blocked_d;
      standby_q <= standby_d;
    end
  end

  assign o_busy_in_progress = busy_q;
  assign o_write_enable_latch = wel_q;
  assign o_deep_sleep = sleep_q;
  assign o_standby = standby_q;
  assign o_erase_chip = chip_q;
  assign o_erase_blk = blk_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  AST_BLK_ERASE_START: assert property (
    (frame_go && st_q == ST_IDLE && op == `OP_BLK_ERASE && len == `LEN_ADDR_CMD &&
     wel_q && !prot_hit)
    |=> (busy_q && !chip_q && blk_q == $past(addr[`BLK_IDX_MSB:`BLK_IDX_LSB])))
    else $error("Valid block erase did not start");

  AST_BLK_ERASE_LEN: assert property (
    (frame_go && st_q == ST_IDLE && op == `OP_BLK_ERASE && len != `LEN_ADDR_CMD)
    |=> !busy_q)
    else $error("Block erase of wrong length ran");

  AST_BLK_PROTECTED: assert property (
    (frame_go && st_q == ST_IDLE && op == `OP_BLK_ERASE && prot_hit) |=> !busy_q)
    else $error("Protected block was erased");

  AST_CHIP_PROTECTED: assert property (
    (frame_go && st_q == ST_IDLE && !chip_ok &&
     (op == `OP_CHIP_ERASE_A || op == `OP_CHIP_ERASE_B)) |=> !busy_q)
    else $error("Chip erase ran with protection set");

  AST_CHIP_ERASE_HOLD: assert property (
    $rose(busy_q) && chip_q |-> (busy_q && !wel_q)[*8])
    else $error("Chip erase busy dropped early or latch kept");

  AST_WEL_GATES_ERASE: assert property (
    $rose(busy_q) |-> $past(wel_q) && !wel_q)
    else $error("Erase began without the write enable latch");

  AST_ERASE_ENDS: assert property (
    (busy_q && tmr_q == 32'h0) |=> !busy_q && st_q == ST_IDLE)
    else $error("Busy did not clear at the end of the erase");

  AST_SLEEP_ENTRY: assert property (
    (frame_go && st_q == ST_IDLE && op == `OP_DEEP_SLEEP && is_bare(len))
    |=> (blocked_q && !sleep_q)[*2])
    else $error("Deep sleep entry delay not honoured");

  AST_SLEEP_IGNORES: assert property (
    (frame_go && st_q == ST_SLEEP && op != `OP_WAKE_ID && op != `OP_RST_ENABLE &&
     op != `OP_RST) |=> sleep_q)
    else $error("Command other than release acted in deep sleep");

  AST_BUSY_REJECTS: assert property (
    (frame_go && busy_q && (op == `OP_DEEP_SLEEP || op == `OP_WAKE_ID))
    |=> busy_q && !blocked_q)
    else $error("Sleep or wake disturbed a busy cycle");

  AST_WAKE_HOLDS: assert property (
    (frame_go && st_q == ST_SLEEP && op == `OP_WAKE_ID && is_bare(len))
    |=> (blocked_q && !sleep_q)[*3])
    else $error("Release delay cut short");

  AST_STANDBY: assert property (
    o_standby |-> !busy_q && !blocked_q)
    else $error("Standby shown during an internal cycle");

  AST_STANDBY_SET: assert property (
    (cs_s && st_q == ST_IDLE && !frame_go) |=> o_standby)
    else $error("Standby not shown while deselected and idle");

  AST_WEL_SET: assert property (
    (frame_go && st_q == ST_IDLE && op == `OP_WR_ENABLE && is_bare(len)) |=> wel_q)
    else $error("Write enable frame did not set the latch");

  // Busy may only drop once the timer has run out
  AST_BUSY_HOLDS: assert property (
    (busy_q && tmr_q != 32'h0) |=> busy_q)
    else $error("Busy dropped before the erase time ran out");

  AST_CHIP_ERASE_START: assert property (
    (frame_go && st_q == ST_IDLE && (op == `OP_CHIP_ERASE_A || op == `OP_CHIP_ERASE_B) &&
     is_bare(len) && wel_q && chip_ok) |=> (busy_q && chip_q && !wel_q))
    else $error("Valid chip erase did not start");

  AST_CHIP_ERASE_LEN: assert property (
    (frame_go && st_q == ST_IDLE && !is_bare(len) &&
     (op == `OP_CHIP_ERASE_A || op == `OP_CHIP_ERASE_B)) |=> !busy_q)
    else $error("Chip erase with extra bits ran");

  AST_SLEEP_LEN: assert property (
    (frame_go && st_q == ST_IDLE && op == `OP_DEEP_SLEEP && !is_bare(len))
    |=> !blocked_q)
    else $error("Deep sleep begun on a frame of wrong length");

  AST_SLEEP_ENTERS: assert property (
    (st_q == ST_ENTER && tmr_q == 32'h0) |=> sleep_q)
    else $error("Deep sleep not reached after the entry delay");

  AST_RESET_WAKE: assert property (
    (frame_go && st_q == ST_SLEEP && is_bare(len) &&
     (op == `OP_RST_ENABLE || op == `OP_RST)) |=> !sleep_q && !blocked_q)
    else $error("Reset command did not release deep sleep");

  // The delays are long; a few cycles are enough to show the state is held
  AST_ID_WAKE: assert property (
    (frame_go && st_q == ST_SLEEP && op == `OP_WAKE_ID && len >= `LEN_ADDR_CMD)
    |=> (blocked_q && !sleep_q)[*3])
    else $error("ID-form release did not begin its delay");

  AST_WAKE_ENDS: assert property (
    (st_q == ST_WAKE && tmr_q == 32'h0) |=> st_q == ST_IDLE && !blocked_q)
    else $error("Release delay did not end in idle");

  // ------------------------------------------------------------
  // Cover points
  // ------------------------------------------------------------
  COV_BLK_ERASE: cover property ($rose(busy_q) && !chip_q);
  COV_CHIP_ERASE: cover property ($rose(busy_q) && chip_q);
  COV_SLEEP: cover property ($rose(sleep_q));
  COV_WAKE: cover property ($fell(sleep_q) ##[1:1000] st_q == ST_IDLE);
  COV_ID_WAKE: cover property (frame_go && st_q == ST_SLEEP && op == `OP_WAKE_ID && !is_bare(len));
endmodule : flash_cmd_core

// File: rtl/flash_params.svh
// Constants for the serial flash erase, deep sleep and ID block
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH
`define OP_WR_ENABLE 8'h06
`define OP_BLK_ERASE 8'hd8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hc7
`define OP_DEEP_SLEEP 8'hb9
`define OP_WAKE_ID 8'hab
`define OP_RST_ENABLE 8'h66
`define OP_RST 8'h99
`define OP_ID_X1 8'h90
`define OP_ID_X2 8'h92
`define OP_ID_X4 8'h94
`define LEN_OPCODE 6'h08
`define LEN_ADDR_CMD 6'h20
`define ID_X2_START 6'h14
`define ID_X4_START 6'h0e
`define LEN_MAX 6'h3f
`define BLK_IDX_MSB 22
`define BLK_IDX_LSB 16
`define BLK_COUNT 8'h80
`define CLK_PERIOD_NS 32'h8
`define T_BLK_ERASE_US 32'h1f4
`define T_CHIP_ERASE_US 32'h4e20
`define T_ENTER_SLEEP_US 32'h3
`define T_WAKE_US 32'h3
`define T_WAKE_ID_US 32'h2
`define US_TO_CYC(t) (((t) * 32'h3e8 + `CLK_PERIOD_NS - 32'h1) / `CLK_PERIOD_NS)
`endif

// File: rtl/flash_pkg.sv
// Types shared by the flash command block
package flash_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ERASE, ST_ENTER, ST_SLEEP, ST_WAKE
  } fl_state_t;
endpackage : flash_pkg

// File: rtl/sync3.sv
// Three-stage synchroniser whose output moves when stages two and three agree
`timescale 1ns/1ps
module sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  always_comb begin
    lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      lvl_q <= RST;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end
  assign o_level = lvl_q;
endmodule : sync3

// File: rtl/flash_link.sv
// Serial-clock side: shifts in command frames and drives ID data out
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_link #(
  parameter logic [7:0] MAKER_ID = 8'h5a,
  parameter logic [7:0] DEVICE_ID = 8'h3c
) (
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_rst,
  input wire logic [3:0] i_io,
  input wire logic i_busy,
  input wire logic i_blocked,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  output logic [7:0] o_op,
  output logic [23:0] o_addr,
  output logic [5:0] o_len,
  output logic o_tog
);
  logic [5:0] cnt_q, cnt_d, start;
  logic [3:0] dptr_q, dptr_d, w, out_q, out_d, oe_q, oe_d;
  logic [7:0] op_q, op_d;
  logic [23:0] addr_q, addr_d;
  logic [5:0] len_q;
  logic tog_q, tog_d, en, busy_s, blocked_s, addr_ok;
  logic [15:0] word;
  // Status levels are slow; the opcode phase gives the chain time to settle
  sync3 #(.W(2), .RST(2'b00)) u_sync (
    .i_clk(i_sclk), .i_rst(1'b0), .i_async({i_busy, i_blocked}),
    .o_level({busy_s, blocked_s})
  );
  always_comb begin
    cnt_d = (cnt_q == `LEN_MAX) ? cnt_q : cnt_q + 6'h01;
    tog_d = (cnt_q == 6'h00) ? ~tog_q : tog_q;
    op_d = (cnt_q < `LEN_OPCODE) ? {op_q[6:0], i_io[0]} : op_q;
    addr_ok = (addr_q[23:1] == 23'h0);
    word = addr_q[0] ? {DEVICE_ID, MAKER_ID} : {MAKER_ID, DEVICE_ID};
    addr_d = addr_q;
    start = `LEN_ADDR_CMD;
    w = 4'h1;
    en = 1'b0;
    case (op_q)
      `OP_ID_X2: begin
        if (cnt_q >= `LEN_OPCODE && cnt_q < `ID_X2_START) addr_d = {addr_q[21:0], i_io[1:0]};
        start = `ID_X2_START;
        w = 4'h2;
        en = !blocked_s && addr_ok;
      end
      `OP_ID_X4: begin
        if (cnt_q >= `LEN_OPCODE && cnt_q < `ID_X4_START) addr_d = {addr_q[19:0], i_io};
        start = `ID_X4_START;
        w = 4'h4;
        en = !blocked_s && addr_ok;
      end
      default: begin
        if (cnt_q >= `LEN_OPCODE && cnt_q < `LEN_ADDR_CMD) addr_d = {addr_q[22:0], i_io[0]};
        if (op_q == `OP_ID_X1) en = !blocked_s && addr_ok;
        if (op_q == `OP_WAKE_ID) begin
          en = !busy_s;
          word = {DEVICE_ID, DEVICE_ID};
        end
      end
    endcase
    dptr_d = (en && cnt_q >= start) ? dptr_q + w : dptr_q;
    out_d = 4'h0;
    oe_d = 4'h0;
    if (en && cnt_q >= start) begin
      case (w)
        4'h1: begin
          out_d = {2'b00, word[4'hf - dptr_q], 1'b0};
          oe_d = 4'h2;
        end
        4'h2: begin
          out_d = {2'b00, word[4'hf - dptr_q -: 2]};
          oe_d = 4'h3;
        end
        default: begin
          out_d = word[4'hf - dptr_q -: 4];
          oe_d = 4'hf;
        end
      endcase
    end
  end
  // Select high clears the frame counter; the frame record below survives it
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt_q <= 6'h00;
      dptr_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
      dptr_q <= dptr_d;
    end
  end
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      op_q <= 8'h00;
      addr_q <= 24'h0;
      len_q <= 6'h00;
      tog_q <= 1'b0;
    end else begin
      op_q <= op_d;
      addr_q <= addr_d;
      len_q <= cnt_d;
      tog_q <= tog_d;
    end
  end
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end
  assign o_io = out_q;
  assign o_io_oe = oe_q;
  assign o_op = op_q;
  assign o_addr = addr_q;
  assign o_len = len_q;
  assign o_tog = tog_q;

  AST_OE_AFTER_ADDR: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    (oe_q != 4'h0) |-> (cnt_q >= start && cnt_q >= `ID_X4_START))
    else $error("ID driven before the address phase ended");
  AST_QUAD_ALL_LINES: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    (oe_q != 4'h0 && op_q == `OP_ID_X4) |-> (oe_q == 4'hf))
    else $error("Quad ID form not on four lines");
endmodule : flash_link

// File: tb/flash_host.sv
// Host controller model that frames commands on the serial flash link
`timescale 1ns/1ps
module flash_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io,
  input wire logic [3:0] i_dev_io,
  input wire logic [3:0] i_dev_oe
);
  logic [3:0] h_dat;
  logic [3:0] h_oe;
  logic [3:0] fill;
  logic [3:0] smp;
  logic [3:0] dv;
  // ---------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------
  // Undriven lines toggle so a stale bit never passes for data
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_io[k] = i_dev_oe[k] ? i_dev_io[k] : (h_oe[k] ? h_dat[k] : fill[k]);
    end
  end
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    h_dat = 4'h0;
    h_oe = 4'h0;
    fill = 4'h5;
    forever #24 fill = ~fill;
  end
  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  // Clock runs only inside a frame; data moves while the clock is low
  task automatic pulse(input logic [3:0] d, input logic [3:0] oe);
    h_dat = d;
    h_oe = oe;
    #24;
    o_sclk = 1'b1;
    smp = o_io;
    dv = i_dev_oe;
    #24;
    o_sclk = 1'b0;
  endtask : pulse
  task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int ac,
      input int aw, input int rc, input int rw, output logic [31:0] rd, output logic seen);
    rd = 32'h0;
    seen = 1'b0;
    #3;
    o_cs_n = 1'b0;
    for (int i = 0; i < 8; i++) begin
      pulse({3'h0, op[7 - i]}, 4'h1);
    end
    for (int i = 0; i < ac; i++) begin
      pulse(ad[23:20] >> (4 - aw), 4'((1 << aw) - 1));
      ad = ad << aw;
    end
    for (int i = 0; i < rc; i++) begin
      pulse(4'h0, 4'h0);
      rd = (rd << rw) | 32'(rw == 1 ? {3'h0, smp[1]} : smp & 4'((1 << rw) - 1));
      seen = seen | (|dv);
    end
    // Raised only after the last falling edge so the bit count is exact
    o_cs_n = 1'b1;
    h_oe = 4'h0;
  endtask : frame
endmodule : flash_host

// File: tb/flash_cmd_core_test.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module flash_cmd_core_test;
  import flash_pkg::*;
  localparam logic [7:0] MK = 8'h71; // Arbitrary maker code
  localparam logic [7:0] DV = 8'h2e; // Arbitrary device code
  logic clk;
  logic rst;
  logic [4:0] pf;
  logic pc;
  wire logic sclk;
  wire logic cs_n;
  wire logic [3:0] io;
  logic [3:0] dio;
  logic [3:0] doe;
  logic busy, write_enable_latch, slp, stby, echip;
  logic [6:0] eblk;
  logic [31:0] rd;
  logic seen;
  int errors;
  int checks;
  int n;
  logic [7:0] idop [3] = '{8'h90, 8'h92, 8'h94};
  logic [2:0] cpf [4] = '{3'h0, 3'h7, 3'h1, 3'h0};
  flash_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(io), .i_dev_io(dio), .i_dev_oe(doe));
  // Short erase counts keep the run brief
  flash_cmd_core #(.BLK_ERASE_CYC(400), .CHIP_ERASE_CYC(1000), .MAKER_ID(MK),
      .DEVICE_ID(DV)) dut_u (
    .i_clk_sys(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io),
    .o_io(dio), .o_io_oe(doe), .i_protect_field(pf), .i_protect_complement(pc),
    .o_busy_in_progress(busy), .o_write_enable_latch(write_enable_latch), .o_deep_sleep(slp),
    .o_standby(stby), .o_erase_chip(echip), .o_erase_blk(eblk));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask : tdone
  // Gap after each frame covers the select-high spacing
  task automatic send(input logic [7:0] op, input logic [23:0] ad = 24'h0, input int ac = 0);
    host_u.frame(op, ad, ac, 1, 0, 1, rd, seen);
    cyc(10);
  endtask : send
  task automatic wait_idle(output int k);
    k = 0;
    while (busy !== 1'b0) begin
      k++;
      @(negedge clk);
      if (k > 2000) begin
        errors++;
        $display("[ERR] busy_wait exp 0 got %b", busy);
        complete_run();
      end
    end
  endtask : wait_idle
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b0;
    pf = 5'h00;
    pc = 1'b0;
    errors = 0;
    checks = 0;
    // Reset rises after time zero so the link's edge-triggered clear is seen
    @(negedge clk);
    rst = 1'b1;
    cyc(12);
    rst = 1'b0;
    cyc(4);
    for (int i = 0; i < 6; i++) begin
      n = 1 << (i / 2);
      host_u.frame(idop[i / 2], 24'(i % 2), 24 / n, n, 16 / n, n, rd, seen);
      chk("id_word", i % 2 ? {16'h0, DV, MK} : {16'h0, MK, DV}, rd);
      cyc(10);
    end
    host_u.frame(8'h90, 24'h2, 24, 1, 16, 1, rd, seen);
    chk("id_bad_addr_oe", 0, seen);
    cyc(10);
    host_u.frame(8'hab, 24'h0, 24, 1, 32, 1, rd, seen);
    chk("dev_id_stream", {4{DV}}, rd);
    cyc(10);
    chk("standby", 1, stby);
    tdone("id");
    send(8'hd8, 24'h05abcd, 24);
    chk("busy_no_wel", 0, busy);
    send(8'h06);
    chk("wel", 1, write_enable_latch);
    send(8'hd8, 24'h05abcd, 16);
    chk("busy_short", 0, busy);
    send(8'hd8, 24'h05abcd, 24);
    chk("busy", 1, busy);
    chk("wel_clr", 0, write_enable_latch);
    chk("blk", 7'h05, eblk);
    chk("standby_busy", 0, stby);
    wait_idle(n);
    chk("blk_time", 1, n > 380 && n < 400);
    pf = 5'h01;
    send(8'h06);
    send(8'hd8, 24'h7f1234, 24);
    chk("busy_prot", 0, busy);
    pf = 5'h09;
    send(8'hd8, 24'h000000, 24);
    chk("busy_prot_bot", 0, busy);
    pf = 5'h01;
    send(8'h06);
    send(8'hd8, 24'h000000, 24);
    chk("busy_open", 1, busy);
    wait_idle(n);
    tdone("block_erase");
    for (int j = 0; j < 4; j++) begin
      pf = {2'h0, cpf[j]};
      pc = 1'(j % 2);
      send(8'h06);
      send(j % 2 ? 8'hc7 : 8'h60);
      chk("chip_busy", j < 2, busy);
      if (j < 2) begin
        chk("chip_kind", 1, echip);
        chk("chip_wel", 0, write_enable_latch);
        send(8'hb9);
        host_u.frame(8'hab, 24'h0, 24, 1, 8, 1, rd, seen);
        chk("ab_busy_oe", 0, seen);
        chk("busy_kept", 1, busy);
        wait_idle(n);
        cyc(400);
        chk("no_sleep", 0, slp);
      end
    end
    pf = 5'h00;
    pc = 1'b0;
    send(8'h06);
    send(8'hc7, 24'h0, 8);
    chk("chip_addr", 0, busy);
    tdone("chip_erase");
    send(8'hb9, 24'h0, 8);
    cyc(400);
    chk("sleep_long", 0, slp);
    send(8'hb9);
    cyc(290);
    chk("sleep_wait", 0, slp);
    cyc(100);
    chk("sleep", 1, slp);
    chk("standby_sleep", 0, stby);
    send(8'h06);
    send(8'hd8, 24'h0, 24);
    chk("sleep_erase", 0, busy);
    host_u.frame(8'h90, 24'h0, 24, 1, 16, 1, rd, seen);
    chk("sleep_id_oe", 0, seen);
    cyc(10);
    send(8'hab);
    cyc(400);
    chk("wake", 0, slp);
    chk("standby_wake", 1, stby);
    for (int j = 0; j < 2; j++) begin
      send(8'hb9);
      cyc(400);
      chk("sleep_again", 1, slp);
      send(j ? 8'h99 : 8'h66);
      chk("reset_wake", 0, slp);
    end
    send(8'hb9);
    cyc(400);
    host_u.frame(8'hab, 24'h0, 24, 1, 8, 1, rd, seen);
    chk("id_wake_word", {24'h0, DV}, rd);
    cyc(300);
    chk("id_wake", 0, slp);
    chk("standby_id_wake", 1, stby);
    tdone("deep_sleep");
    complete_run();
  end
endmodule : flash_cmd_core_test
